// ### common/pbctl_link_if.sv
`timescale 1ns/10ps
interface pbctl_link_if;
  logic h_scl_o;
  logic h_scl_oe_n;
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups: low whenever any enabled driver pulls low
  assign scl = ~(~h_scl_oe_n & ~h_scl_o);
  assign sda = ~((~h_sda_oe_n & ~h_sda_o) | (~d_sda_oe_n & ~d_sda_o));

  modport dev (input scl, input sda, output d_sda_o, output d_sda_oe_n);
  modport host (input scl, input sda, output h_scl_o, output h_scl_oe_n,
                output h_sda_o, output h_sda_oe_n);
endinterface : pbctl_link_if

// ### common/pbctl_pkg.sv
package pbctl_pkg;
  // Clock and link timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_TIMEOUT_MS = 260;
  localparam int RST_HOLD_CYC = RST_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SCL_PERIOD_NS = 2500;
  // Quarter of the serial clock period, rounded up so the period is never too short
  localparam int SCL_QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

  // Serial slave address and the one mapped register
  localparam logic [6:0] DEV_ADDR = 7'h5a;
  localparam logic [7:0] REG_SYS_CTRL = 8'h06;
  localparam int BTN_STATE_BIT = 0;
  localparam int UNMASK_BIT = 1;
  localparam int WEXACT_BIT = 4;
  localparam logic UNMASK_RST = 1'b1;
  localparam logic WEXACT_RST = 1'b0;

  // Controller register offsets
  localparam logic [3:0] HREG_CTRL = 4'h0;
  localparam logic [3:0] HREG_REGADDR = 4'h1;
  localparam logic [3:0] HREG_WDATA = 4'h2;
  localparam logic [3:0] HREG_RDATA = 4'h3;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_MASK = 4'h5;
  // Controller register fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_READ_BIT = 1;
  localparam int CTRL_BUSY_BIT = 7;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [1:0] MASK_RST = 2'h0;
endpackage : pbctl_pkg

// ### src/pbctl_dev.sv
`timescale 1ns/10ps
// Behaviour
// - Serial slave only, answers address 1011010.
// - Single-byte write and single-byte read only.
// - START restarts decoding from the address byte.
// - Eight-bit bytes, MSB first, sampled rising SCL.
// - Device acknowledges its address and each byte written; host leaves the read byte unacknowledged.
// - Bit 0 shows live button state.
// - Bit 1 is button interrupt unmask.
// - Bits 3:2 and 7:5 ignore writes.
// - Host writes bit 4 with its default.
// - Resistor press requests startup or shutdown.
// - Ground press drives reset low immediately.
// - Reset held until release plus timeout.
// - Interrupt follows button, clears on release.
// - Host touches only mapped register addresses.
module pbctl_dev #(
  parameter int RST_HOLD = pbctl_pkg::RST_HOLD_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  pbctl_link_if.dev lnk,
  input wire logic press_res_i,
  input wire logic press_gnd_i,
  output logic system_reset_out_n_o,
  output logic interrupt_out_n_o,
  output logic startup_req_o,
  output logic button_state_flag_o
);
  import pbctl_pkg::*;

  localparam int RCW = 25;

  // Refuse hold times the countdown cannot represent
  if (RST_HOLD < 1 || RST_HOLD >= 2 ** RCW) begin : g_chk
    $error("pbctl_dev: RST_HOLD out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_REG,
    S_WDATA,
    S_ACK,
    S_RDATA,
    S_RACK
  } dev_state_e;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    dev_state_e st;
    dev_state_e nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic sda_low;
    logic unmask;
    logic wexact;
    logic [RCW-1:0] rcnt;
    logic rst_n;
    logic irq_n;
    logic start_req;
    logic btn;
  } dev_s;

  localparam dev_s DEV_RST = '{
    scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1,
    sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
    st: S_IDLE, nxt: S_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00,
    sda_low: 1'b0, unmask: UNMASK_RST, wexact: WEXACT_RST,
    rcnt: '0, rst_n: 1'b1, irq_n: 1'b1, start_req: 1'b0, btn: 1'b0
  };

  dev_s q;
  dev_s d;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic btn_c;
  logic [7:0] rd_val;

  // Edges come from the second synchroniser stage and its own history only
  assign scl_rise = q.scl_s & ~q.scl_p;
  assign scl_fall = ~q.scl_s & q.scl_p;
  assign start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
  assign stop_c = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
  assign btn_c = press_res_i | press_gnd_i;

  // Read view of the control register; unmapped addresses read zero
  always_comb begin
    rd_val = 8'h00;
    if (q.ptr == REG_SYS_CTRL) begin
      rd_val[BTN_STATE_BIT] = btn_c;
      rd_val[UNMASK_BIT] = q.unmask;
      rd_val[WEXACT_BIT] = q.wexact;
    end
  end

  // Next-state logic for the serial slave and the button logic
  always_comb begin
    d = q;
    d.scl_m = lnk.scl;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = lnk.sda;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;

    if (start_c) begin
      // A start aborts whatever was in flight, even mid-byte
      d.st = S_ADDR;
      d.cnt = 4'h0;
      d.sda_low = 1'b0;
    end else if (stop_c) begin
      d.st = S_IDLE;
      d.sda_low = 1'b0;
    end else begin
      case (q.st)
        S_IDLE: begin
          d.sda_low = 1'b0;
        end
        S_ADDR, S_REG, S_WDATA: begin
          if (scl_rise && q.cnt < 4'h8) begin
            d.sh = {q.sh[6:0], q.sda_s};
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall && q.cnt == 4'h8) begin
            d.cnt = 4'h0;
            d.st = S_ACK;
            d.sda_low = 1'b1;
            case (q.st)
              S_ADDR: begin
                if (q.sh[7:1] != DEV_ADDR) begin
                  // Not ours: stay off the bus until the next start
                  d.st = S_IDLE;
                  d.sda_low = 1'b0;
                end else if (q.sh[0]) begin
                  d.nxt = S_RDATA;
                end else begin
                  d.nxt = S_REG;
                end
              end
              S_REG: begin
                d.ptr = q.sh;
                d.nxt = S_WDATA;
              end
              default: begin
                // Only the unmask and fixed bits take a write
                if (q.ptr == REG_SYS_CTRL) begin
                  d.unmask = q.sh[UNMASK_BIT];
                  d.wexact = q.sh[WEXACT_BIT];
                end
                d.nxt = S_IDLE;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            d.st = q.nxt;
            d.sda_low = 1'b0;
            if (q.nxt == S_RDATA) begin
              d.sh = rd_val;
              d.sda_low = ~rd_val[7];
            end
          end
        end
        S_RDATA: begin
          if (scl_rise) begin
            d.cnt = q.cnt + 4'h1;
          end else if (scl_fall) begin
            if (q.cnt == 4'h8) begin
              d.sda_low = 1'b0; // Master answers the byte
              d.st = S_RACK;
              d.cnt = 4'h0;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_low = ~q.sh[6];
            end
          end
        end
        S_RACK: begin
          // One byte per read; the master's acknowledge is not acted on
          if (scl_rise) begin
            d.st = S_IDLE;
          end
        end
        default: begin
          d.st = S_IDLE;
          d.sda_low = 1'b0;
        end
      endcase
    end

    // Ground press outranks the resistor press and restarts the hold
    if (press_gnd_i) begin
      d.rst_n = 1'b0;
      d.rcnt = RCW'(RST_HOLD);
    end else if (q.rcnt > RCW'(1)) begin
      d.rcnt = q.rcnt - RCW'(1);
    end else if (q.rcnt == RCW'(1)) begin
      d.rcnt = '0;
      d.rst_n = 1'b1;
    end
    d.start_req = press_res_i & ~press_gnd_i;
    d.btn = btn_c;
    d.irq_n = ~(btn_c & q.unmask);
  end

  // Single state register; clock enable low freezes everything
  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q <= DEV_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Pin drives low only; enable is active low
  assign lnk.d_sda_o = 1'b0;
  assign lnk.d_sda_oe_n = ~q.sda_low;
  assign system_reset_out_n_o = q.rst_n;
  assign interrupt_out_n_o = q.irq_n;
  assign startup_req_o = q.start_req;
  assign button_state_flag_o = q.btn;
endmodule : pbctl_dev

// ### src/pbctl_host.sv
// Chosen here: strobed register access.
`timescale 1ns/10ps
module pbctl_host #(
  parameter int QTR = pbctl_pkg::SCL_QTR_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  pbctl_link_if.host lnk,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [7:0] rdata_o,
  output logic irq_o
);
  import pbctl_pkg::*;

  if (QTR < 2 || QTR > 255) begin : g_chk
    $error("pbctl_host: QTR out of range");
  end

  typedef enum logic [1:0] {
    K_START,
    K_TX,
    K_RX,
    K_STOP
  } kind_e;

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    logic busy;
    logic rw;
    logic [2:0] item;
    logic [3:0] bitn;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic scl_low;
    logic sda_low;
    logic [7:0] sh;
    logic [7:0] regad;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic irq;
  } host_s;

  localparam host_s HOST_RST = '{
    sda_m: 1'b1, sda_s: 1'b1, busy: 1'b0, rw: 1'b0, item: 3'h0, bitn: 4'h0,
    ph: 2'h0, qcnt: 8'h00, scl_low: 1'b0, sda_low: 1'b0, sh: 8'h00,
    regad: 8'h00, wdat: 8'h00, rdat: 8'h00, stat: 2'h0, mask: MASK_RST,
    rdata: 8'h00, irq: 1'b0
  };

  host_s q;
  host_s d;

  // Write: S addr+W reg data P; read: S addr+W reg Sr addr+R data P
  function automatic kind_e item_kind(input logic rw, input logic [2:0] it);
    kind_e k;
    k = K_TX;
    if (it == 3'h0 || (rw && it == 3'h3)) begin
      k = K_START;
    end else if ((!rw && it == 3'h4) || (rw && it == 3'h6)) begin
      k = K_STOP;
    end else if (rw && it == 3'h5) begin
      k = K_RX;
    end
    return k;
  endfunction : item_kind

  function automatic logic [7:0] item_byte(input host_s s, input logic [2:0] it);
    logic [7:0] b;
    b = {DEV_ADDR, 1'b0};
    if (it == 3'h2) begin
      b = s.regad;
    end else if (it == 3'h3) begin
      b = s.wdat;
    end else if (it == 3'h4) begin
      b = {DEV_ADDR, 1'b1};
    end
    return b;
  endfunction : item_byte

  kind_e k;
  logic [1:0] set_ev;

  always_comb begin
    d = q;
    set_ev = 2'h0;
    k = item_kind(q.rw, q.item);
    d.sda_m = lnk.sda;
    d.sda_s = q.sda_m;

    // Sequencer: four quarter-period phases per slot
    if (q.busy) begin
      if (q.qcnt != 8'h00) begin
        d.qcnt = q.qcnt - 8'h01;
      end else begin
        d.qcnt = 8'(QTR - 1);
        d.ph = q.ph + 2'h1;
        case (q.ph)
          2'h0: begin
            // Data changes only while SCL is low
            if (k == K_START) begin
              d.sda_low = 1'b0;
            end else if (k == K_STOP) begin
              d.sda_low = 1'b1;
            end else begin
              d.sda_low = (k == K_TX && q.bitn < 4'h8) ? ~q.sh[7] : 1'b0;
            end
          end
          2'h1: begin
            d.scl_low = 1'b0;
          end
          2'h2: begin
            if (k == K_START) begin
              d.sda_low = 1'b1;
            end else if (k == K_STOP) begin
              d.sda_low = 1'b0;
            end else if (k == K_RX && q.bitn < 4'h8) begin
              d.sh = {q.sh[6:0], q.sda_s};
            end else if (k == K_TX && q.bitn == 4'h8 && q.sda_s) begin
              set_ev[STAT_NACK_BIT] = 1'b1;
            end
          end
          default: begin
            if (k == K_STOP) begin
              d.busy = 1'b0;
              set_ev[STAT_DONE_BIT] = 1'b1;
            end else begin
              d.scl_low = 1'b1;
              if (k == K_TX || k == K_RX) begin
                d.bitn = q.bitn + 4'h1;
                if (k == K_TX) begin
                  d.sh = {q.sh[6:0], 1'b0};
                end
              end
              if (k == K_START || q.bitn == 4'h8) begin
                d.bitn = 4'h0;
                d.item = q.item + 3'h1;
                if (k == K_RX) begin
                  d.rdat = q.sh;
                end
                // A refused byte skips straight to the stop slot
                if (k == K_TX && q.sda_s) begin
                  d.item = q.rw ? 3'h6 : 3'h4;
                end
                d.sh = item_byte(q, q.item + 3'h1);
              end
            end
          end
        endcase
      end
    end

    // Register port; a go while busy is ignored
    d.rdata = 8'h00;
    if (re_i) begin
      case (addr_i)
        HREG_CTRL: d.rdata = {q.busy, 5'h00, q.rw, 1'b0};
        HREG_REGADDR: d.rdata = q.regad;
        HREG_WDATA: d.rdata = q.wdat;
        HREG_RDATA: d.rdata = q.rdat;
        HREG_STATUS: d.rdata = {6'h00, q.stat};
        HREG_MASK: d.rdata = {6'h00, q.mask};
        default: d.rdata = 8'h00;
      endcase
    end
    if (we_i) begin
      case (addr_i)
        HREG_CTRL: begin
          if (wdata_i[CTRL_GO_BIT] && !q.busy) begin
            d.busy = 1'b1;
            d.rw = wdata_i[CTRL_READ_BIT];
            d.item = 3'h0;
            d.bitn = 4'h0;
            d.ph = 2'h0;
            d.qcnt = 8'(QTR - 1);
          end
        end
        HREG_REGADDR: d.regad = wdata_i;
        HREG_WDATA: d.wdat = wdata_i;
        HREG_MASK: d.mask = wdata_i[1:0];
        default: begin
        end
      endcase
    end
    // Set beats clear so an event in the clearing cycle survives
    if (we_i && addr_i == HREG_STATUS) begin
      d.stat = (q.stat & ~wdata_i[1:0]) | set_ev;
    end else begin
      d.stat = q.stat | set_ev;
    end
    d.irq = |(d.stat & d.mask);
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      q <= HOST_RST;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Both pins only ever pull low
  assign lnk.h_scl_o = 1'b0;
  assign lnk.h_scl_oe_n = ~q.scl_low;
  assign lnk.h_sda_o = 1'b0;
  assign lnk.h_sda_oe_n = ~q.sda_low;
  assign rdata_o = q.rdata;
  assign irq_o = q.irq;
endmodule : pbctl_host

// ### tb/pbctl_sva.sv
`timescale 1ns/10ps
module pbctl_sva (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_oe_n,
  input wire logic press_res_i,
  input wire logic press_gnd_i,
  input wire logic system_reset_out_n_o,
  input wire logic interrupt_out_n_o,
  input wire logic startup_req_o,
  input wire logic button_state_flag_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  // Either press counts as a pressed button
  logic btn;
  assign btn = press_res_i | press_gnd_i;

  // Button side
  a_gnd_reset_low: assert property (press_gnd_i |=> !system_reset_out_n_o)
    else $error("reset output not low after ground press");
  a_reset_after_release: assert property ($rose(system_reset_out_n_o) |-> !$past(press_gnd_i))
    else $error("reset output released while ground press held");
  a_irq_has_cause: assert property (!interrupt_out_n_o |-> $past(btn))
    else $error("interrupt low without a press");
  a_irq_self_clear: assert property (!btn |=> interrupt_out_n_o)
    else $error("interrupt still low after release");
  a_flag_live: assert property (1'b1 |=> button_state_flag_o == $past(btn))
    else $error("button flag does not follow the button");
  a_startup_only_res: assert property (startup_req_o |-> $past(press_res_i && !press_gnd_i))
    else $error("startup request without a resistor press");
  a_startup_follows: assert property (press_res_i && !press_gnd_i |=> startup_req_o)
    else $error("resistor press gave no startup request");
  // Wire side: device moves data only with the clock low, so no false START or STOP
  a_dev_sda_scl_low: assert property ($changed(d_sda_oe_n) |-> !scl)
    else $error("device changed data line while clock high");
  a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
    else $error("serial clock high phase too short");

  c_dev_ack: cover property ($fell(d_sda_oe_n));
  c_reset_done: cover property ($rose(system_reset_out_n_o));
  c_irq: cover property ($fell(interrupt_out_n_o));
  c_startup: cover property ($rose(startup_req_o));
  c_start: cover property (scl && $fell(sda));
endmodule : pbctl_sva

// ### tb/test_pmic_i2c_pushbutton_ctrl.sv
`timescale 1ns/10ps
module test_pmic_i2c_pushbutton_ctrl;
  import pbctl_pkg::*;
  localparam int HOLD = 20;
  logic mclk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic we = 1'b0;
  logic re = 1'b0;
  logic pres = 1'b0;
  logic pgnd = 1'b0;
  logic ce = 1'b1;
  logic frz = 1'b0;
  logic [7:0] rdata;
  logic irq, rst_n, irq_n, sreq, flag;
  logic first = 1'b0;
  logic m_unmask = UNMASK_RST;
  logic m_mask = 1'b0;
  logic [7:0] sh = 8'h00;
  logic [7:0] wire_byte = 8'h00;
  logic [7:0] got;
  logic [7:0] d;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int nbit = 0;
  int n;

  pbctl_link_if lnk ();
  pbctl_dev #(.RST_HOLD(HOLD)) u_pbctl_dev (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .lnk(lnk), .press_res_i(pres), .press_gnd_i(pgnd), .system_reset_out_n_o(rst_n),
    .interrupt_out_n_o(irq_n), .startup_req_o(sreq), .button_state_flag_o(flag));
  // Quarter period of 8 leaves room for the device's three-cycle sampling lag
  pbctl_host #(.QTR(8)) u_pbctl_host (.mclk_i(mclk_i), .rstn_i(rstn_i), .ce_i(ce),
    .lnk(lnk), .addr_i(addr), .wdata_i(wdata), .we_i(we), .re_i(re), .rdata_o(rdata),
    .irq_o(irq));
  pbctl_sva u_pbctl_sva (.mclk_i(mclk_i), .rstn_i(rstn_i), .scl(lnk.scl), .sda(lnk.sda),
    .d_sda_oe_n(lnk.d_sda_oe_n), .press_res_i(pres), .press_gnd_i(pgnd),
    .system_reset_out_n_o(rst_n), .interrupt_out_n_o(irq_n), .startup_req_o(sreq),
    .button_state_flag_o(flag));

  initial forever #5 mclk_i = ~mclk_i;

  // Hang guard, well above the longest expected run
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Register port; a gap cycle keeps each strobe from being set twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge mclk_i);
    we <= 1'b0;
    @(posedge mclk_i);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    addr <= a;
    re <= 1'b1;
    @(posedge mclk_i);
    re <= 1'b0;
    #1 v = rdata;
    @(posedge mclk_i);
  endtask : rd

  // One serial transaction run through the controller
  task automatic xfer(input logic rdn, input logic [7:0] ra, input logic [7:0] wd,
                      output logic [7:0] v);
    logic [7:0] s;
    logic [1:0] w;
    int k;
    s = 8'h00;
    wr(HREG_REGADDR, ra);
    wr(HREG_WDATA, wd);
    wr(HREG_CTRL, {6'h00, rdn, 1'b1});
    if (frz) begin
      // Freeze both ends mid-frame; 48 cycles is one and a half clock slots, so a live link would move
      repeat (300) @(posedge mclk_i);
      ce <= 1'b0;
      @(posedge mclk_i);
      #1 w = {lnk.scl, lnk.sda};
      repeat (48) @(posedge mclk_i);
      #1 check("ce_hold", {6'h00, lnk.scl, lnk.sda}, {6'h00, w});
      @(posedge mclk_i);
      ce <= 1'b1;
    end
    for (k = 0; k < 2000 && s[STAT_DONE_BIT] !== 1'b1; k++) rd(HREG_STATUS, s);
    check("status", s & 8'h03, 8'h01);
    check("irq_o", {7'h00, irq}, {7'h00, m_mask});
    wr(HREG_STATUS, 8'h03);
    check("irq_clr", {7'h00, irq}, 8'h00);
    rd(HREG_RDATA, v);
  endtask : xfer

  task automatic btn(input logic r, input logic g, input logic [3:0] e);
    @(posedge mclk_i);
    pres <= r;
    pgnd <= g;
    repeat (2) @(posedge mclk_i);
    #1 check("pins", {4'h0, irq_n, sreq, flag, rst_n}, {4'h0, e});
    @(posedge mclk_i);
  endtask : btn

  // Wire monitor: START restarts counting, bits taken on the clock's rise
  always @(negedge lnk.sda) if (lnk.scl === 1'b1) begin
    nbit = 0;
    first = 1'b1;
  end
  always @(posedge lnk.scl) begin
    if (nbit < 8) sh = {sh[6:0], lnk.sda};
    else begin
      wire_byte = sh;
      if (first) begin
        check("addr_byte", {1'b0, sh[7:1]}, {1'b0, DEV_ADDR});
        check("addr_ack", {7'h00, lnk.sda}, 8'h00);
      end
      first = 1'b0;
    end
    nbit = (nbit == 8) ? 0 : nbit + 1;
  end

  initial begin
    void'($urandom(24));
    repeat (2) @(posedge mclk_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rd(HREG_STATUS, got);
    check("status_rst", got, 8'h00);
    rd(HREG_MASK, got);
    check("mask_rst", got, {6'h00, MASK_RST});
    wr(4'hf, 8'hff);
    rd(4'hf, got);
    check("unmapped", got, 8'h00);
    xfer(1'b1, REG_SYS_CTRL, 8'h00, got);
    check("sys_rst", got, {6'h00, UNMASK_RST, 1'b0});
    rd(HREG_CTRL, got);
    check("ctrl_idle", got, 8'h02);
    rd(HREG_REGADDR, got);
    check("regaddr_rb", got, REG_SYS_CTRL);
    // Random writes; bit 4 always carries its default
    for (int i = 0; i < 4; i++) begin
      frz = (i == 1);
      d = 8'($urandom) & 8'hef;
      d[1] = i[0];
      m_mask = i[1];
      wr(HREG_MASK, {7'h00, m_mask});
      xfer(1'b0, REG_SYS_CTRL, d, got);
      check("wire_wdata", wire_byte, d);
      m_unmask = d[1];
      xfer(1'b1, REG_SYS_CTRL, 8'h00, got);
      check("sys_rb", got, {6'h00, m_unmask, 1'b0});
      check("wire_rdata", wire_byte, {6'h00, m_unmask, 1'b0});
    end
    // Reserved bits of the mapped register ignore writes
    xfer(1'b0, REG_SYS_CTRL, 8'hee, got);
    xfer(1'b1, REG_SYS_CTRL, 8'h00, got);
    check("sys_resv", got, 8'h02);
    // Resistor press, unmasked then masked
    btn(1'b1, 1'b0, 4'b0111);
    xfer(1'b1, REG_SYS_CTRL, 8'h00, got);
    check("sys_pressed", got, 8'h03);
    btn(1'b0, 1'b0, 4'b1001);
    xfer(1'b0, REG_SYS_CTRL, 8'h00, got);
    btn(1'b1, 1'b0, 4'b1111);
    // Ground press wins over the resistor press
    btn(1'b1, 1'b1, 4'b1010);
    repeat (30) @(posedge mclk_i);
    check("rst_held", {7'h00, rst_n}, 8'h00);
    pres <= 1'b0;
    pgnd <= 1'b0;
    for (n = 0; n < 100 && rst_n !== 1'b1; n++) begin
      @(posedge mclk_i);
      #1;
    end
    check("rst_wait", {7'h00, n >= HOLD && n <= HOLD + 2}, 8'h01);
    conclude();
  end
endmodule : test_pmic_i2c_pushbutton_ctrl
